// file: core/hcs_config_store.sv
/*
 * Configuration store and reload sequencer of the high speed counter unit.
 * Holds a staged set written by the host and the active set seen by the
 * counters. Assumes run_mode is synchronous and counters obey counters_halt.
 */
`timescale 1ns/10ps
module hcs_config_store
    import hcs_pkg::*;
#(
    parameter bit HAS_DC_OUTPUTS = 1'b1
)(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  run_mode,
    input  wire logic [CH_N-1:0]       counter_out_raw,
    input  wire logic [CH_N-1:0]       user_out,
    output logic                       counters_halt,
    output logic                       counters_restart,
    output logic                       quadrature_plus_single_arrangement,
    output logic [CH_N-1:0]            ch_enable,
    output logic [CH_N-1:0]            ch_out_enable,
    output logic [CH_N-1:0]            ch_count_down,
    output logic [CH_N-1:0]            ch_single_pass,
    output logic [CH_N-1:0]            ch_aux_strobe,
    output logic [CH_N-1:0]            ch_strobe_neg,
    output logic [CH_N-1:0]            ch_count_neg,
    output logic [CH_N*NUM_W-1:0]      ch_timebase,
    output logic [CH_N*NUM_W-1:0]      ch_hi_limit,
    output logic [CH_N*NUM_W-1:0]      ch_lo_limit,
    output logic [CH_N*NUM_W-1:0]      ch_on_preset,
    output logic [CH_N*NUM_W-1:0]      ch_off_preset,
    output logic [CH_N*NUM_W-1:0]      ch_preload,
    output logic                       ch1_pwm_enable,
    output logic                       ch1_pulse_enable,
    output logic [CH_N-1:0]            output_pins
);

    function automatic logic [15:0] num_default(input int idx);
        unique case (idx)
            N_TB:    num_default = TB_RESET;
            N_HI:    num_default = HI_RESET;
            N_ON:    num_default = ON_RESET;
            default: num_default = ZERO_RST;
        endcase
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  strb);
        merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction

    hcs_state_t         state, next_state;
    logic [FLG_W-1:0]   stg_flg [CH_N];
    logic [FLG_W-1:0]   act_flg [CH_N];
    logic [FLG_W-1:0]   next_stg_flg [CH_N];
    logic [FLG_W-1:0]   next_act_flg [CH_N];
    logic [15:0]        stg_num [CH_N][NUM_N];
    logic [15:0]        act_num [CH_N][NUM_N];
    logic [15:0]        next_stg_num [CH_N][NUM_N];
    logic [15:0]        next_act_num [CH_N][NUM_N];
    logic [2:0]         stg_glb, act_glb, next_stg_glb, next_act_glb;
    logic               run_q, next_run_q;
    logic               rt_rej, rt_acc, next_rt_rej, next_rt_acc;
    logic               aw_full, w_full, next_aw_full, next_w_full;
    logic [ADDR_W-1:0]  aw_addr, next_aw_addr;
    logic [31:0]        w_data, next_w_data;
    logic [3:0]         w_strb, next_w_strb;
    logic               bvalid, next_bvalid;
    logic [1:0]         bresp, next_bresp;
    logic               rvalid, next_rvalid;
    logic [1:0]         rresp, next_rresp;
    logic [31:0]        rdata, next_rdata;
    logic [CH_N-1:0]    pins, next_pins;
    logic               quad;
    hcs_fail_t          fail_mode;

    assign quad      = act_glb[G_QUAD];
    assign fail_mode = hcs_fail_t'(act_glb[2:1]);

    assign s_axi_awready = !aw_full && !bvalid;
    assign s_axi_wready  = !w_full && !bvalid;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;

    // counters held stopped through halt and apply
    assign counters_halt    = (state == ST_HALT) || (state == ST_APPLY);
    assign counters_restart = (state == ST_RESTART);
    assign quadrature_plus_single_arrangement = quad;
    assign output_pins      = pins;
    // pulse outputs only on DC variants and four-single arrangement
    assign ch1_pwm_enable   = HAS_DC_OUTPUTS && !quad && act_flg[0][F_PWM];
    assign ch1_pulse_enable = HAS_DC_OUTPUTS && !quad && act_flg[0][F_PULSE];

    for (genvar i = 0; i < CH_N; i++) begin : g_ch
        // channels two and three fold into the quadrature counter
        localparam bit FOLDED = (i == 1) || (i == 2);
        localparam bit QCH    = (i == 0);
        assign ch_enable[i]      = act_flg[i][F_EN] && !(quad && FOLDED);
        assign ch_out_enable[i]  = act_flg[i][F_OUT] && !(quad && FOLDED);
        assign ch_count_down[i]  = act_flg[i][F_DOWN] && !(quad && QCH);
        assign ch_single_pass[i] = act_flg[i][F_SINGLE] && !(quad && QCH);
        assign ch_aux_strobe[i]  = act_flg[i][F_STROBE];
        assign ch_strobe_neg[i]  = act_flg[i][F_STB_NEG];
        assign ch_count_neg[i]   = act_flg[i][F_CNT_NEG] && !(quad && QCH);
        assign ch_timebase[i*NUM_W +: NUM_W]   = act_num[i][N_TB];
        assign ch_hi_limit[i*NUM_W +: NUM_W]   = act_num[i][N_HI];
        assign ch_lo_limit[i*NUM_W +: NUM_W]   = act_num[i][N_LO];
        assign ch_on_preset[i*NUM_W +: NUM_W]  = act_num[i][N_ON];
        assign ch_off_preset[i*NUM_W +: NUM_W] = act_num[i][N_OFF];
        assign ch_preload[i*NUM_W +: NUM_W]    = act_num[i][N_PLD];
    end

    always_comb begin
        logic        do_wr;
        logic        rt_ok;
        logic [1:0]  rt_ch;
        logic [2:0]  rt_fld;
        logic [1:0]  wch;
        logic [2:0]  wwd;
        logic [1:0]  rch;
        logic [2:0]  rwd;
        do_wr  = 1'b0;
        rt_ok  = 1'b0;
        rt_ch  = w_data[1:0];
        rt_fld = w_data[6:4];
        wch    = aw_addr[6:5];
        wwd    = aw_addr[4:2];
        rch    = s_axi_araddr[6:5];
        rwd    = s_axi_araddr[4:2];
        next_state   = state;
        next_stg_flg = stg_flg;
        next_act_flg = act_flg;
        next_stg_num = stg_num;
        next_act_num = act_num;
        next_stg_glb = stg_glb;
        next_act_glb = act_glb;
        next_run_q   = run_mode;
        next_rt_rej  = rt_rej;
        next_rt_acc  = rt_acc;
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        next_pins    = pins;

        // reload sequence on a stop-to-run edge seen while idle
        unique case (state)
            ST_IDLE: begin
                if (run_mode && !run_q) begin
                    next_state = ST_HALT;
                end
            end
            ST_HALT: begin
                next_state = ST_APPLY;
            end
            ST_APPLY: begin
                next_act_flg = stg_flg;
                next_act_num = stg_num;
                next_act_glb = stg_glb;
                next_state   = ST_RESTART;
            end
            ST_RESTART: begin
                next_state = ST_IDLE;
            end
        endcase

        // write channel: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_full && w_full && !bvalid) begin
            do_wr        = 1'b1;
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OK;
        end

        if (do_wr) begin
            if (aw_addr == A_GLB_STG) begin
                if (w_strb[0]) begin
                    next_stg_glb = w_data[2:0];
                end
            end else if (aw_addr == A_STATUS) begin
                if (w_strb[0] && w_data[S_REJ]) begin
                    next_rt_rej = 1'b0;
                end
                if (w_strb[0] && w_data[S_ACC]) begin
                    next_rt_acc = 1'b0;
                end
            end else if (aw_addr == A_RT_REQ) begin
                // only numeric fields, only enabled channels, not mid-reload
                rt_ok = (w_strb == 4'hF) && (state == ST_IDLE)
                        && act_flg[rt_ch][F_EN] && (rt_fld < 3'(NUM_N));
                if (rt_ok) begin
                    next_act_num[rt_ch][rt_fld] = w_data[31:16];
                    next_rt_acc = 1'b1;
                end else begin
                    next_rt_rej = 1'b1;
                end
            end else if (aw_addr[8:7] == REG_STG && wwd == 3'h0) begin
                next_stg_flg[wch] = FLG_W'(merge16(16'(stg_flg[wch]), w_data, w_strb));
            end else if (aw_addr[8:7] == REG_STG && wwd <= 3'(NUM_N)) begin
                next_stg_num[wch][wwd-3'h1] = merge16(stg_num[wch][wwd-3'h1], w_data, w_strb);
            end else begin
                next_bresp = RESP_ERR;
            end
        end

        // read channel, one cycle after the address is taken
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OK;
            next_rdata  = 32'h0000_0000;
            if (s_axi_araddr == A_GLB_STG) begin
                next_rdata = {29'h0, stg_glb};
            end else if (s_axi_araddr == A_GLB_ACT) begin
                next_rdata = {29'h0, act_glb};
            end else if (s_axi_araddr == A_STATUS) begin
                next_rdata = {28'h0, rt_acc, rt_rej, state != ST_IDLE, run_q};
            end else if (s_axi_araddr == A_RT_REQ) begin
                next_rdata = 32'h0000_0000;
            end else if (s_axi_araddr[8] && rwd == 3'h0) begin
                next_rdata = {23'h0, s_axi_araddr[7] ? act_flg[rch] : stg_flg[rch]};
            end else if (s_axi_araddr[8] && rwd <= 3'(NUM_N)) begin
                next_rdata = {16'h0, s_axi_araddr[7] ? act_num[rch][rwd-3'h1]
                                                     : stg_num[rch][rwd-3'h1]};
            end else begin
                next_rresp = RESP_ERR;
            end
        end

        // set wins over a clear in the same cycle
        if (rt_ok) begin
            next_rt_acc = 1'b1;
        end else if (do_wr && aw_addr == A_RT_REQ) begin
            next_rt_rej = 1'b1;
        end

        // output pins: user owns them unless the counter reserves them
        for (int i = 0; i < CH_N; i++) begin
            if (!ch_out_enable[i] || !ch_enable[i]) begin
                next_pins[i] = user_out[i];
            end else if (run_mode || fail_mode == FAIL_NORMAL || fail_mode == FAIL_RSVD) begin
                next_pins[i] = counter_out_raw[i];
            end else if (fail_mode == FAIL_OFF) begin
                next_pins[i] = 1'b0;
            end else begin
                next_pins[i] = pins[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state   <= ST_IDLE;
            stg_glb <= GLB_RESET;
            act_glb <= GLB_RESET;
            for (int i = 0; i < CH_N; i++) begin
                stg_flg[i] <= FLG_RESET;
                act_flg[i] <= FLG_RESET;
                for (int n = 0; n < NUM_N; n++) begin
                    stg_num[i][n] <= num_default(n);
                    act_num[i][n] <= num_default(n);
                end
            end
            run_q   <= 1'b0;
            rt_rej  <= 1'b0;
            rt_acc  <= 1'b0;
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= '0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OK;
            rvalid  <= 1'b0;
            rresp   <= RESP_OK;
            rdata   <= 32'h0000_0000;
            pins    <= 4'h0;
        end else begin
            state   <= next_state;
            stg_glb <= next_stg_glb;
            act_glb <= next_act_glb;
            stg_flg <= next_stg_flg;
            act_flg <= next_act_flg;
            stg_num <= next_stg_num;
            act_num <= next_act_num;
            run_q   <= next_run_q;
            rt_rej  <= next_rt_rej;
            rt_acc  <= next_rt_acc;
            aw_full <= next_aw_full;
            w_full  <= next_w_full;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
            pins    <= next_pins;
        end
    end

endmodule

// file: core/hcs_pkg.sv
/*
 * Constants shared by the configuration store of the four-channel
 * high speed counter unit: register map, field layout, reset values.
 * Assumes a 32-bit AXI4-Lite host bus and one 40 MHz controller clock.
 */
// Notes on behaviour
// - stop-to-run transfer becomes new parameter set
// - reload halts, applies, then restarts all counters
// - power-up leaves every parameter at default
// - runtime requests touch only statically enabled counters
// - arrangement and failure mode, documented defaults
// - four identical channel sets, up, continuous
// - counter and output enables default disabled
// - auxiliary input selects preload or strobe
// - strobe edge selectable, positive default
// - count edge selectable, positive default
// - numeric defaults 1000, 32767, 0, 32767, zeros
// - channel one pulse enables, DC variants only
// - quadrature uses channels one-three, four single
// - quadrature ignores direction, mode, count edge
// - failure mode governs outputs while stopped
package hcs_pkg;
    localparam int CH_N    = 4;
    localparam int NUM_N   = 6;
    localparam int NUM_W   = 16;
    localparam int FLG_W   = 9;
    localparam int ADDR_W  = 9;
    // register byte offsets
    localparam logic [8:0] A_GLB_STG = 9'h000;
    localparam logic [8:0] A_STATUS  = 9'h004;
    localparam logic [8:0] A_RT_REQ  = 9'h008;
    localparam logic [8:0] A_GLB_ACT = 9'h00C;
    localparam logic [1:0] REG_STG   = 2'h2;
    localparam logic [1:0] REG_ACT   = 2'h3;
    // channel flag bits
    localparam int F_EN      = 0;
    localparam int F_OUT     = 1;
    localparam int F_DOWN    = 2;
    localparam int F_SINGLE  = 3;
    localparam int F_STROBE  = 4;
    localparam int F_STB_NEG = 5;
    localparam int F_CNT_NEG = 6;
    localparam int F_PWM     = 7;
    localparam int F_PULSE   = 8;
    localparam logic [FLG_W-1:0] FLG_RESET = 9'h000;
    // numeric word index
    localparam int N_TB  = 0;
    localparam int N_HI  = 1;
    localparam int N_LO  = 2;
    localparam int N_ON  = 3;
    localparam int N_OFF = 4;
    localparam int N_PLD = 5;
    localparam logic [15:0] TB_RESET  = 16'h03E8;
    localparam logic [15:0] HI_RESET  = 16'h7FFF;
    localparam logic [15:0] ON_RESET  = 16'h7FFF;
    localparam logic [15:0] ZERO_RST  = 16'h0000;
    // global bits
    localparam int G_QUAD = 0;
    localparam logic [2:0] GLB_RESET = 3'h0;
    // status bits
    localparam int S_RUN = 0;
    localparam int S_BUSY = 1;
    localparam int S_REJ = 2;
    localparam int S_ACC = 3;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [1:0] {FAIL_NORMAL, FAIL_OFF, FAIL_HOLD, FAIL_RSVD} hcs_fail_t;
    typedef enum {ST_IDLE, ST_HALT, ST_APPLY, ST_RESTART} hcs_state_t;
endpackage

// file: verif/hcs_config_store_bench.sv
/*
 * Self-checking bench of the configuration store over AXI4-Lite.
 * Assumes hcs_pkg, the store, its checker and the host model compiled first.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module hcs_config_store_bench
    import hcs_pkg::*;
;
    logic              aclk, aresetn, want_run, run_mode, s_axi_awvalid, s_axi_wvalid;
    logic              s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
    logic              s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic              counters_halt, counters_restart, quadrature_plus_single_arrangement;
    logic              ch1_pwm_enable, ch1_pulse_enable;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, d;
    logic [1:0]        s_axi_bresp, s_axi_rresp, r;
    logic [3:0]        s_axi_wstrb, counter_out_raw, user_out, output_pins, p;
    logic [3:0]        ch_enable, ch_out_enable, ch_count_down, ch_single_pass;
    logic [3:0]        ch_aux_strobe, ch_strobe_neg, ch_count_neg;
    logic [63:0]       ch_timebase, ch_hi_limit, ch_lo_limit, ch_on_preset;
    logic [63:0]       ch_off_preset, ch_preload;
    logic [63:0]       nums [6];
    logic [29:0]       flg;
    int                num_checks = 0;
    int                miscompares = 0;

    assign nums = '{ch_timebase, ch_hi_limit, ch_lo_limit, ch_on_preset, ch_off_preset,
                    ch_preload};
    assign flg = {ch_enable, ch_out_enable, ch_count_down, ch_single_pass, ch_aux_strobe,
                  ch_strobe_neg, ch_count_neg, ch1_pwm_enable, ch1_pulse_enable};

    hcs_config_store dut (.*);
    hcs_host_model host (.*);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    function automatic logic [15:0] dflt(int w);
        return (w == 1) ? 16'h03E8 : (w == 2 || w == 4) ? 16'h7FFF : 16'h0000;
    endfunction

    task automatic axi_wr(input logic [8:0] a, input logic [31:0] v, input logic [1:0] e);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        `CHK(s_axi_bvalid, 1'b1)
        `CHK(s_axi_bresp, e)
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [8:0] a, output logic [31:0] v, output logic [1:0] e);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        v = s_axi_rdata;
        e = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic chk_rd(input logic [8:0] a, input logic [31:0] v);
        axi_rd(a, d, r);
        `CHK(d, v)
        `CHK(r, RESP_OK)
    endtask

    // run drops long enough for the store to see a clean rising edge
    task automatic reload();
        int n;
        n = 0;
        want_run <= 1'b0;
        repeat (3) @(posedge aclk);
        want_run <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!counters_restart && n < 20);
        `CHK(counters_restart, 1'b1)
        @(posedge aclk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a few hundred cycles are needed; this span is ample
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        finish_test();
    end

    initial begin
        {aresetn, want_run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        user_out = 4'hA;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(flg, 30'h0)
        for (int g = 0; g < 2; g++) begin
            for (int c = 0; c < 4; c++) begin
                for (int w = 0; w < 7; w++) begin
                    if (w > 0) `CHK(nums[w-1][16*c +: 16], dflt(w))
                    chk_rd(9'(256 + 128*g + 32*c + 4*w), 32'(dflt(w)));
                end
            end
        end
        chk_rd(A_GLB_ACT, 32'h0);
        axi_wr(A_RT_REQ, 32'h1234_0000, RESP_OK);
        `CHK(nums[0][15:0], 16'h03E8)
        chk_rd(A_STATUS, 32'h4);
        axi_rd(9'h11C, d, r);
        `CHK(r, RESP_ERR)
        `CHK(d, 32'h0)
        axi_wr(9'h180, 32'h1, RESP_ERR);
        chk_rd(9'h180, 32'h0);
        $display("test defaults done");
        for (int c = 0; c < 4; c++) begin
            axi_wr(9'(256 + 32*c), 32'(9'h1FF >> c), RESP_OK);
            for (int w = 1; w < 7; w++) axi_wr(9'(256 + 32*c + 4*w), 32'(4096*w + c), RESP_OK);
        end
        axi_wr(A_GLB_STG, 32'h2, RESP_OK);
        `CHK(flg, 30'h0)
        reload();
        `CHK(flg, {24'hFFFFFF, 4'h7, 2'h3})
        for (int c = 0; c < 4; c++) begin
            for (int w = 1; w < 7; w++) `CHK(nums[w-1][16*c +: 16], 16'(4096*w + c))
        end
        want_run <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK(output_pins, 4'h0)
        axi_wr(A_GLB_STG, 32'h4, RESP_OK);
        reload();
        want_run <= 1'b0;
        repeat (3) @(posedge aclk);
        p = output_pins;
        // odd wait: toggling counter outputs would otherwise look held
        repeat (3) @(posedge aclk);
        `CHK(output_pins, p)
        chk_rd(A_GLB_ACT, 32'h4);
        $display("test reload done");
        axi_wr(A_GLB_STG, 32'h0, RESP_OK);
        axi_wr(9'h160, 32'h3E, RESP_OK);
        reload();
        `CHK(flg, {4'h7, 20'hFFFFF, 4'h7, 2'h3})
        axi_wr(A_RT_REQ, 32'h0555_0013, RESP_OK);
        axi_wr(A_RT_REQ, 32'h0123_0021, RESP_OK);
        `CHK(nums[1][63:48], 16'h2003)
        `CHK(nums[2][31:16], 16'h0123)
        chk_rd(A_STATUS, 32'hD);
        axi_wr(A_STATUS, 32'hC, RESP_OK);
        chk_rd(A_STATUS, 32'h1);
        // channel four left disabled, so its pin stays with the program
        user_out <= 4'h5;
        repeat (2) @(posedge aclk);
        `CHK(output_pins[3], 1'b0)
        $display("test runtime done");
        axi_wr(A_GLB_STG, 32'h1, RESP_OK);
        reload();
        `CHK(quadrature_plus_single_arrangement, 1'b1)
        `CHK(flg, {4'h1, 4'h9, 8'hEE, 8'hFF, 4'h6, 2'h0})
        // normal failure mode: stopped counters still drive their pins
        want_run <= 1'b0;
        repeat (2) @(posedge aclk);
        p = counter_out_raw;
        @(posedge aclk);
        `CHK(output_pins[0], p[0])
        $display("test quadrature done");
        finish_test();
    end
endmodule

// file: verif/hcs_config_store_properties.sv
/*
 * Port checks of the configuration store: reload order, reset values,
 * arrangement masking and output pin selection.
 * Assumes hcs_pkg is compiled first; bound into every hcs_config_store.
 */
`timescale 1ns/10ps
module hcs_config_store_properties
    import hcs_pkg::*;
(
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 run_mode,
    input wire logic [CH_N-1:0]      counter_out_raw,
    input wire logic [CH_N-1:0]      user_out,
    input wire logic                 counters_halt,
    input wire logic                 counters_restart,
    input wire logic                 quadrature_plus_single_arrangement,
    input wire logic [CH_N-1:0]      ch_enable,
    input wire logic [CH_N-1:0]      ch_out_enable,
    input wire logic [CH_N-1:0]      ch_count_down,
    input wire logic [CH_N-1:0]      ch_single_pass,
    input wire logic [CH_N-1:0]      ch_count_neg,
    input wire logic [CH_N*NUM_W-1:0] ch_timebase,
    input wire logic [CH_N*NUM_W-1:0] ch_on_preset,
    input wire logic                 ch1_pwm_enable,
    input wire logic                 ch1_pulse_enable,
    input wire logic [CH_N-1:0]      output_pins
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reload_order: assert property (run_mode && !$past(run_mode) && !counters_halt
        && !counters_restart |=> counters_halt [*2] ##1 (!counters_halt && counters_restart))
        else $error("reload sequence out of order");
    a_restart_once: assert property (counters_restart |=> !counters_restart && !counters_halt)
        else $error("restart not a single pulse");
    a_halt_cause: assert property ($rose(counters_halt) |-> $past(run_mode))
        else $error("halt without run request");
    a_flags_hold: assert property (!counters_restart |-> $stable({ch_enable, ch_out_enable,
        ch_count_down, ch_single_pass, ch_count_neg, quadrature_plus_single_arrangement}))
        else $error("flags changed outside reload");
    a_quad_mask: assert property (quadrature_plus_single_arrangement |-> !(ch_enable[1]
        | ch_enable[2] | ch_out_enable[1] | ch_out_enable[2] | ch_count_down[0]
        | ch_single_pass[0] | ch_count_neg[0] | ch1_pwm_enable | ch1_pulse_enable))
        else $error("quadrature masking wrong");
    a_reset_vals: assert property ($rose(aresetn) |-> ch_timebase == {CH_N{TB_RESET}}
        && ch_on_preset == {CH_N{ON_RESET}} && ch_enable == 4'h0)
        else $error("reset values wrong");
    a_user_pins: assert property (ch_enable == 4'h0 |=> output_pins == $past(user_out))
        else $error("pins not from user");
    a_run_pins: assert property (run_mode && (ch_enable & ch_out_enable) == 4'hF
        |=> output_pins == $past(counter_out_raw))
        else $error("pins not from counters");

    c_reload: cover property (counters_restart);
    c_quad: cover property (quadrature_plus_single_arrangement && counters_restart);
    c_run_pins: cover property (run_mode && (ch_enable & ch_out_enable) == 4'hF);
endmodule

bind hcs_config_store hcs_config_store_properties u_props (.*);

// file: verif/hcs_host_model.sv
/*
 * Far-side model: host run/stop switch and a counter bank whose outputs
 * toggle each cycle and freeze while the store halts it.
 * Assumes want_run is driven by the bench after a clock edge.
 */
`timescale 1ns/10ps
module hcs_host_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       want_run,
    input  wire logic       counters_halt,
    output logic            run_mode,
    output logic [3:0]      counter_out_raw
);
    logic       next_run_mode;
    logic [3:0] next_raw;

    always_comb begin
        next_run_mode = want_run;
        next_raw = counters_halt ? counter_out_raw : ~counter_out_raw;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_mode <= 1'b0;
            counter_out_raw <= 4'h5;
        end else begin
            run_mode <= next_run_mode;
            counter_out_raw <= next_raw;
        end
    end
endmodule
